/* File: src/sdi_consts.vh */
// Notes on behaviour
// - Raw bit 5 sets when receive FIFO becomes full; held until cleared.
// - Raw bit 4 sets when receive FIFO level rises above programmed half threshold.
// - Raw bit 3 sets when receive FIFO goes from empty to non-empty.
// - Raw bit 2 sets when transmit FIFO goes from full to not full.
// - Raw bit 1 sets when transmit free space rises above programmed half threshold.
// - Raw bit 0 sets when transmit FIFO becomes empty.
// - Mask register at 0x04, one bit per source 18..0, 1 blocks, reset all masked.
// - Masking never alters the raw latched state of any source.
// - Writing one to a clear register bit at 0x08 clears that latched source.
// - Clear acts only on bits 17..0; bits 31..18 have no effect.
// - Card interrupt bit 18 follows the card input; maskable, not clearable.
`ifndef SDI_CONSTS_VH
`define SDI_CONSTS_VH
`define SDI_ADDR_W        8
`define SDI_OFS_RAW       8'h00
`define SDI_OFS_MASK      8'h04
`define SDI_OFS_CLEAR     8'h08
`define SDI_OFS_LEVEL     8'h0c
`define SDI_NSRC          19
`define SDI_NCLR          18
`define SDI_MASK_RESET    19'h7ffff
`define SDI_RAW_RESET     19'h00000
`define SDI_BIT_TX_EMPTY  0
`define SDI_BIT_TX_HALF   1
`define SDI_BIT_TX_NFULL  2
`define SDI_BIT_RX_NEMPTY 3
`define SDI_BIT_RX_HALF   4
`define SDI_BIT_RX_FULL   5
`define SDI_BIT_EVT_LSB   6
`define SDI_BIT_CARD      18
`define SDI_LVL_RX_LSB    0
`define SDI_LVL_TX_LSB    16
`define SDI_LVL_W         16
`endif

/* File: src/sdi_edge_latch.v */
`include "sdi_consts.vh"
// One sticky source: sets on rising edge of its condition, set wins over clear
module sdi_edge_latch (
	// Clock and reset
	input  wire CLK,
	input  wire RESETN,
	// Condition and clear
	input  wire cond,
	input  wire clr,
	// Latched state
	output wire flag
);
	reg cond_q;
	reg flag_q;
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cond_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			cond_q <= cond;
			if (cond && !cond_q)
				flag_q <= 1'b1;
			else if (clr)
				flag_q <= 1'b0;
		end
	end
	assign flag = flag_q;
endmodule

/* File: src/sdi_irq_ctrl.v */
// Added by the designer: the address-and-strobe port.
`include "sdi_consts.vh"
module sdi_irq_ctrl #(
	parameter LVL_W = `SDI_LVL_W,
	parameter DEPTH = 16'd64
) (
	// Clock and reset
	input  wire                   CLK,
	input  wire                   RESETN,
	// Register port
	input  wire [`SDI_ADDR_W-1:0] ADDR,
	input  wire [31:0]            WDATA,
	input  wire                   WR,
	input  wire                   RD,
	output wire [31:0]            RDATA,
	// Receive FIFO level, bytes held
	input  wire [LVL_W-1:0]       RX_LEVEL,
	// Transmit FIFO free space, bytes
	input  wire [LVL_W-1:0]       TX_SPACE,
	// Other source events, one-cycle pulses, bits 17..6
	input  wire [11:0]            EVENT_IN,
	// Card interrupt level from the card side
	input  wire                   CARD_IRQ,
	// Interrupt
	output wire                   IRQ
);
	reg  [`SDI_NSRC-1:0] mask_q;
	reg  [LVL_W-1:0]     rx_half_q;
	reg  [LVL_W-1:0]     tx_half_q;
	reg  [31:0]          rdata_q;
	reg                  card_s1_q;
	reg                  card_s2_q;
	reg  [`SDI_NSRC-1:0] cond;
	reg  [31:0]          rdata_d;
	wire [`SDI_NSRC-1:0] raw;
	wire                 wr_clear;
	wire [`SDI_NCLR-1:0] clr_vec;

	// Writes of one clear, zero leaves alone, upper bits ignored
	assign wr_clear = WR && (ADDR == `SDI_OFS_CLEAR);
	assign clr_vec  = wr_clear ? WDATA[`SDI_NCLR-1:0] : {`SDI_NCLR{1'b0}};

	// Card input crosses from outside the clock domain
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			card_s1_q <= 1'b0;
			card_s2_q <= 1'b0;
		end else begin
			card_s1_q <= CARD_IRQ;
			card_s2_q <= card_s1_q;
		end
	end

	// Conditions whose rising edge latches each source
	always @* begin
		cond = {`SDI_NSRC{1'b0}};
		cond[`SDI_BIT_TX_EMPTY]  = (TX_SPACE == DEPTH[LVL_W-1:0]);
		cond[`SDI_BIT_TX_HALF]   = (TX_SPACE > tx_half_q);
		cond[`SDI_BIT_TX_NFULL]  = (TX_SPACE != {LVL_W{1'b0}});
		cond[`SDI_BIT_RX_NEMPTY] = (RX_LEVEL != {LVL_W{1'b0}});
		cond[`SDI_BIT_RX_HALF]   = (RX_LEVEL > rx_half_q);
		cond[`SDI_BIT_RX_FULL]   = (RX_LEVEL == DEPTH[LVL_W-1:0]);
		cond[`SDI_NCLR-1:`SDI_BIT_EVT_LSB] = EVENT_IN;
	end

	genvar i;
	generate
		for (i = 0; i < `SDI_NCLR; i = i + 1) begin : g_src
			sdi_edge_latch u_latch (
				.CLK    (CLK),
				.RESETN (RESETN),
				.cond   (cond[i]),
				.clr    (clr_vec[i]),
				.flag   (raw[i])
			);
		end
	endgenerate

	// Card source is a live level, not clearable here
	assign raw[`SDI_BIT_CARD] = card_s2_q;

	// Register writes
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mask_q    <= `SDI_MASK_RESET;
			rx_half_q <= {LVL_W{1'b0}};
			tx_half_q <= {LVL_W{1'b0}};
		end else if (WR) begin
			if (ADDR == `SDI_OFS_MASK)
				mask_q <= WDATA[`SDI_NSRC-1:0];
			if (ADDR == `SDI_OFS_LEVEL) begin
				rx_half_q <= WDATA[`SDI_LVL_RX_LSB +: LVL_W];
				tx_half_q <= WDATA[`SDI_LVL_TX_LSB +: LVL_W];
			end
		end
	end

	// Read mux, data one cycle after strobe, unmapped reads zero
	always @* begin
		rdata_d = 32'h00000000;
		case (ADDR)
			`SDI_OFS_RAW:   rdata_d[`SDI_NSRC-1:0] = raw;
			`SDI_OFS_MASK:  rdata_d[`SDI_NSRC-1:0] = mask_q;
			`SDI_OFS_LEVEL: begin
				rdata_d[`SDI_LVL_RX_LSB +: LVL_W] = rx_half_q;
				rdata_d[`SDI_LVL_TX_LSB +: LVL_W] = tx_half_q;
			end
			default:        rdata_d = 32'h00000000;
		endcase
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			rdata_q <= 32'h00000000;
		else if (RD)
			rdata_q <= rdata_d;
		else
			rdata_q <= 32'h00000000;
	end

	assign RDATA = rdata_q;
	assign IRQ   = |(raw & ~mask_q);
endmodule

/* File: verification/sdi_irq_monitor.sv */
module sdi_irq_monitor #(parameter LVL_W = 16, parameter DEPTH = 16'd64) (
	input wire CLK, RESETN, WR, RD, CARD_IRQ, IRQ,
	input wire [7:0] ADDR,
	input wire [31:0] WDATA, RDATA,
	input wire [11:0] EVENT_IN,
	input wire [LVL_W-1:0] RX_LEVEL, TX_SPACE);
timeunit 1ns; timeprecision 1ns;
reg [18:0] m_q;
wire mw = WR && ADDR == 8'h04;
always @(posedge CLK or negedge RESETN)
	if (!RESETN) m_q <= 19'h7ffff; else if (mw) m_q <= WDATA[18:0];
default clocking @(posedge CLK); endclocking
default disable iff (!RESETN);
sequence s_up(c, b); $rose(c) && !m_q[b] && !mw; endsequence
property p_full; s_up(RX_LEVEL == DEPTH, 5) |=> IRQ; endproperty
property p_ne; s_up(RX_LEVEL != 0, 3) |=> IRQ; endproperty
property p_nf; s_up(TX_SPACE != 0, 2) |=> IRQ; endproperty
property p_emp; s_up(TX_SPACE == DEPTH, 0) |=> IRQ; endproperty
property p_mask; m_q == 19'h7ffff |-> !IRQ; endproperty
property p_mrd; RD && ADDR == 8'h04 |=> RDATA == {13'h0, $past(m_q)}; endproperty
property p_clr; RD && ADDR == 8'h08 |=> RDATA == 32'h0; endproperty
property p_card; CARD_IRQ[*4] ##0 !m_q[18] |-> IRQ; endproperty
a_full: assert property (p_full) else $error("rx full irq");
a_ne: assert property (p_ne) else $error("rx nonempty irq");
a_nf: assert property (p_nf) else $error("tx notfull irq");
a_emp: assert property (p_emp) else $error("tx empty irq");
a_mask: assert property (p_mask) else $error("masked irq");
a_mrd: assert property (p_mrd) else $error("mask readback");
a_clr: assert property (p_clr) else $error("clear reg read");
a_card: assert property (p_card) else $error("card irq");
endmodule
bind sdi_irq_ctrl sdi_irq_monitor #(.LVL_W(LVL_W), .DEPTH(DEPTH)) u_mon (.*);

/* File: verification/sdi_irq_ctrl_bench.sv */
module sdi_irq_ctrl_bench;
timeunit 1ns; timeprecision 1ns;
localparam D = 64;
reg CLK = 0, RESETN = 0, WR = 0, RD = 0, CARD_IRQ = 0;
reg [7:0] ADDR = 0;
reg [31:0] WDATA = 0, c;
reg [15:0] RX_LEVEL = 0, TX_SPACE = 0, pr, pt, r, t;
reg [11:0] EVENT_IN = 0, e;
reg [18:0] raw, m;
wire [31:0] RDATA;
wire IRQ;
int miscompares = 0, check_count = 0, cyc = 0, i;
sdi_irq_ctrl #(.DEPTH(D)) dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .RX_LEVEL(RX_LEVEL), .TX_SPACE(TX_SPACE), .EVENT_IN(EVENT_IN), .CARD_IRQ(CARD_IRQ), .IRQ(IRQ));
initial forever #50 CLK = ~CLK;
always @(posedge CLK) if (++cyc == 3000) begin
	miscompares++;
	stop_test;
end
task stop_test;
	$display("mismatches %0d checks %0d", miscompares, check_count);
	if (miscompares == 0 && check_count > 0) $display("STATUS OK");
	else $display("STATUS NOT OK");
	$finish;
endtask
task chk(input [31:0] g, input [31:0] x);
	check_count++;
	if (g !== x) begin
		miscompares++;
		$display("[FAIL] %0t got %h exp %h", $time, g, x);
	end
endtask
task wr(input [7:0] a, input [31:0] d);
	@(posedge CLK); ADDR <= a; WDATA <= d; WR <= 1;
	@(posedge CLK); WR <= 0;
endtask
task rd(input [7:0] a, input [31:0] x);
	@(posedge CLK); ADDR <= a; RD <= 1;
	@(posedge CLK); RD <= 0;
	#1 chk(RDATA, x);
endtask
// Edge flags from previous and new levels, thresholds rx 20 tx 10
function [18:0] fx(input [15:0] a, b, x, y);
	fx = {13'h0, x == D && a != D, x > 20 && a <= 20, x != 0 && a == 0,
		y != 0 && b == 0, y > 10 && b <= 10, y == D && b != D};
endfunction
initial begin
	i = $urandom(78);
	repeat (8) @(posedge CLK);
	RESETN <= 1;
	rd(8'h04, 32'h7ffff);
	rd(8'h08, 0);
	rd(8'h00, 0);
	wr(8'h0c, {16'd10, 16'd20});
	rd(8'h0c, {16'd10, 16'd20});
	$display("register test done");
	for (i = 0; i < 24; i++) begin
		r = ($urandom % 3 == 0) ? D : $urandom % (D + 1);
		t = ($urandom % 3 == 0) ? D : $urandom % (D + 1);
		e = $urandom; c = $urandom; m = $urandom;
		pr = RX_LEVEL; pt = TX_SPACE;
		wr(8'h04, {13'h0, m});
		@(posedge CLK); RX_LEVEL <= r; TX_SPACE <= t; EVENT_IN <= e;
		@(posedge CLK); EVENT_IN <= 0;
		raw = fx(pr, pt, r, t) | {1'b0, e, 6'h0};
		rd(8'h00, {13'h0, raw});
		chk(IRQ, |(raw & ~m));
		wr(8'h08, c);
		rd(8'h00, {13'h0, raw & ~{1'b0, c[17:0]}});
		wr(8'h08, 32'hffffffff);
	end
	$display("random source test done");
	wr(8'h04, 0);
	@(posedge CLK); CARD_IRQ <= 1;
	repeat (4) @(posedge CLK);
	wr(8'h08, 32'hffffffff);
	rd(8'h00, 32'h40000);
	chk(IRQ, 1);
	@(posedge CLK); CARD_IRQ <= 0;
	repeat (4) @(posedge CLK);
	rd(8'h00, 0);
	$display("card test done");
	stop_test;
end
endmodule
